// *** rtl/i2cab_top.sv ***
// Transmit abort cause register of an I2C controller behind an AXI4-Lite slave
//
// What this block does
// R1: Flag 11 is set when a master transfer is requested while the master function is off.
// R2: Flag 10 is set when a 10-bit read is requested while repeated start is off.
// R3: Flag 9 is set when a start byte is requested while repeated start is off.
// R4: Flag 9 cleared while its cause still holds drops for one cycle and then comes back.
// R5: Flag 8 is set when a high-speed transfer is requested while repeated start is off.
// R6: Flag 7 is set when a start byte sent as master is acknowledged.
// R7: Flag 6 is set when the high-speed master code is acknowledged.
// R8: Flag 5 is set when a read command follows a general call.
// R9: Flag 4 is set when a general call gets no acknowledge.
// R10: Flag 3 is set when a data byte after an acknowledged address gets no acknowledge.
// R11: Flag 2 is set when the second 10-bit address byte gets no acknowledge.
// R12: Flag 1 is set when the first 10-bit address byte gets no acknowledge.
// R13: Flag 0 is set when a 7-bit address gets no acknowledge.
// R14: Reading either clear register clears all flags; flag 9 comes back one cycle later while its cause still holds.
// R15: The 32-bit source register shows which cause raised the abort event.
// R16: Flags reset to zero and ignore software writes.
// R17: A flag sets in the cycle after its cause is seen and holds until a clear.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`include "i2cab_defines.svh"
module i2cab_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  // Write address channel
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  // Write response channel
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address channel
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  // Read data channel
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Requests and events from the bus engine
  input  wire logic        xfer_req,
  input  wire logic        xfer_read,
  input  wire logic        addr1_nack,
  input  wire logic        addr2_nack,
  input  wire logic        data_nack,
  input  wire logic        start_byte_acked,
  input  wire logic        hs_code_acked,
  input  wire logic        read_cmd_popped,
  input  wire logic        gcall_active,
  // Configuration toward the bus engine
  output      logic        master_enable,
  output      logic        repeated_start_enable,
  // Abort event toward the interrupt logic
  output      logic        tx_abort_event
);

  // Write channel holding registers
  logic [7:0]              awaddr_q;
  logic                    aw_held_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    w_held_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  // Read channel registers
  logic                    rvalid_q;
  logic [31:0]             rdata_q;
  logic [1:0]              rresp_q;
  // Software registers
  logic [31:0]             control_q;
  logic [31:0]             target_q;
  // Flag storage view
  i2cab_pkg::i2cab_cause_t flags_q;
  logic                    abort_event_q;
  // Handshakes and decoded accesses
  logic                    ar_hs;
  logic                    do_write;
  i2cab_pkg::i2cab_reg_t   wr_reg;
  i2cab_pkg::i2cab_reg_t   rd_reg;
  i2cab_pkg::i2cab_cfg_t   cfg;
  logic                    rd_clear;

  i2cab_cause_if cif ();

  // Maps a byte address onto a register, low two bits ignored
  function automatic i2cab_pkg::i2cab_reg_t decode(input logic [7:0] addr);
    logic [7:0] word;
    word = {addr[7:2], 2'h0};
    if (word == `I2CAB_ADDR_CONTROL) begin
      decode = i2cab_pkg::I2CAB_REG_CONTROL;
    end else if (word == `I2CAB_ADDR_TARGET) begin
      decode = i2cab_pkg::I2CAB_REG_TARGET;
    end else if (word == `I2CAB_ADDR_INTR_CLR) begin
      decode = i2cab_pkg::I2CAB_REG_INTR_CLR;
    end else if (word == `I2CAB_ADDR_ABRT_CLR) begin
      decode = i2cab_pkg::I2CAB_REG_ABRT_CLR;
    end else if (word == `I2CAB_ADDR_SOURCE) begin
      decode = i2cab_pkg::I2CAB_REG_SOURCE;
    end else begin
      decode = i2cab_pkg::I2CAB_REG_NONE;
    end
  endfunction

  // Merges write data into a register under byte strobes and a field mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~(lanes & mask)) | (data & lanes & mask);
  endfunction

  // Channel ready terms, one write in flight at a time
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign ar_hs         = s_axi_arvalid && !rvalid_q;
  assign do_write      = aw_held_q && w_held_q && !bvalid_q;
  assign wr_reg        = decode(awaddr_q);
  assign rd_reg        = decode(s_axi_araddr);

  // Reading a clear register empties the flags at the read handshake
  assign rd_clear = ar_hs && (rd_reg == i2cab_pkg::I2CAB_REG_INTR_CLR ||
                              rd_reg == i2cab_pkg::I2CAB_REG_ABRT_CLR); // R14
  assign cif.clear = rd_clear;

  // Write address capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // Write response, error for addresses outside the map
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `I2CAB_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_reg == i2cab_pkg::I2CAB_REG_NONE) ? `I2CAB_RESP_SLVERR : `I2CAB_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Control register, only implemented bits are writable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      control_q <= `I2CAB_CONTROL_RST;
    end else if (do_write && wr_reg == i2cab_pkg::I2CAB_REG_CONTROL) begin
      control_q <= merge(control_q, wdata_q, wstrb_q, `I2CAB_CONTROL_MASK);
    end
  end

  // Target register, selects for command_select_a commands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      target_q <= `I2CAB_TARGET_RST;
    end else if (do_write && wr_reg == i2cab_pkg::I2CAB_REG_TARGET) begin
      target_q <= merge(target_q, wdata_q, wstrb_q, `I2CAB_TARGET_MASK);
    end
  end

  // Read response, data captured at the handshake before any clear lands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `I2CAB_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `I2CAB_RESP_OKAY;
      unique case (rd_reg)
        i2cab_pkg::I2CAB_REG_CONTROL: begin
          rdata_q <= control_q;
        end
        i2cab_pkg::I2CAB_REG_TARGET: begin
          rdata_q <= target_q;
        end
        i2cab_pkg::I2CAB_REG_INTR_CLR,
        i2cab_pkg::I2CAB_REG_ABRT_CLR: begin
          rdata_q <= {31'h0000_0000, |flags_q};
        end
        i2cab_pkg::I2CAB_REG_SOURCE: begin
          rdata_q <= {20'h0_0000, flags_q}; // R15 R16
        end
        i2cab_pkg::I2CAB_REG_NONE: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `I2CAB_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Configuration view handed to cause detection
  assign cfg.master_en    = control_q[`I2CAB_CTL_MASTER_EN];
  assign cfg.restart_en   = control_q[`I2CAB_CTL_RESTART];
  assign cfg.hs_mode      = control_q[`I2CAB_CTL_HS_MODE];
  assign cfg.ten_bit      = control_q[`I2CAB_CTL_TEN_BIT];
  assign cfg.cmd_sel_a    = target_q[`I2CAB_TAR_CMD_SEL_A];
  assign cfg.gc_start_sel = target_q[`I2CAB_TAR_GC_START];

  // Cause detection from configuration and engine events
  i2cab_cause_detect u_detect (
    .cfg              (cfg),
    .xfer_req         (xfer_req),
    .xfer_read        (xfer_read),
    .addr1_nack       (addr1_nack),
    .addr2_nack       (addr2_nack),
    .data_nack        (data_nack),
    .start_byte_acked (start_byte_acked),
    .hs_code_acked    (hs_code_acked),
    .read_cmd_popped  (read_cmd_popped),
    .gcall_active     (gcall_active),
    .cif              (cif.detect)
  );

  // Sticky flag storage
  i2cab_flags u_flags (
    .clk           (clk),
    .nrst          (nrst),
    .cif           (cif.store),
    .flags_q       (flags_q),
    .abort_event_q (abort_event_q)
  );

  // Outputs
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rdata           = rdata_q;
  assign s_axi_rresp           = rresp_q;
  assign master_enable         = control_q[`I2CAB_CTL_MASTER_EN];
  assign repeated_start_enable = control_q[`I2CAB_CTL_RESTART];
  assign tx_abort_event        = abort_event_q; // R15

endmodule

// *** inc/i2cab_defines.svh ***
// Register map, field positions and reset values of the abort cause block
`ifndef I2CAB_DEFINES_SVH
`define I2CAB_DEFINES_SVH
// Byte addresses of the registers
`define I2CAB_ADDR_CONTROL  8'h00
`define I2CAB_ADDR_TARGET   8'h04
`define I2CAB_ADDR_INTR_CLR 8'h40
`define I2CAB_ADDR_ABRT_CLR 8'h54
`define I2CAB_ADDR_SOURCE   8'h80
// Control register fields
`define I2CAB_CTL_MASTER_EN 0
`define I2CAB_CTL_HS_MODE   1
`define I2CAB_CTL_TEN_BIT   2
`define I2CAB_CTL_RESTART   5
// Target register fields
`define I2CAB_TAR_GC_START  10
`define I2CAB_TAR_CMD_SEL_A 11
// Cause flag positions in the source register
`define I2CAB_F_7B_NACK     0
`define I2CAB_F_10B1_NACK   1
`define I2CAB_F_10B2_NACK   2
`define I2CAB_F_DATA_NACK   3
`define I2CAB_F_GC_NACK     4
`define I2CAB_F_GC_READ     5
`define I2CAB_F_HS_ACKED    6
`define I2CAB_F_SB_ACKED    7
`define I2CAB_F_HS_NORST    8
`define I2CAB_F_SB_NORST    9
`define I2CAB_F_10B_RD      10
`define I2CAB_F_MASTER_DIS  11
// Reset values and writable masks
`define I2CAB_CONTROL_RST   32'h0000_0021
`define I2CAB_CONTROL_MASK  32'h0000_0027
`define I2CAB_TARGET_RST    32'h0000_0000
`define I2CAB_TARGET_MASK   32'h0000_0c00
// Bus responses
`define I2CAB_RESP_OKAY     2'h0
`define I2CAB_RESP_SLVERR   2'h2
`endif

// *** inc/i2cab_pkg.sv ***
// Types shared by the abort cause block
package i2cab_pkg;
  typedef logic [11:0] i2cab_cause_t;
  typedef struct packed {
    logic master_en;
    logic restart_en;
    logic hs_mode;
    logic ten_bit;
    logic cmd_sel_a;
    logic gc_start_sel;
  } i2cab_cfg_t;
  typedef enum logic [2:0] {
    I2CAB_REG_CONTROL,
    I2CAB_REG_TARGET,
    I2CAB_REG_INTR_CLR,
    I2CAB_REG_ABRT_CLR,
    I2CAB_REG_SOURCE,
    I2CAB_REG_NONE
  } i2cab_reg_t;
endpackage

// *** inc/i2cab_cause_if.sv ***
// Carrier between cause detection and flag storage
interface i2cab_cause_if;
  i2cab_pkg::i2cab_cause_t set;
  logic                    sbyte_live;
  logic                    clear;
  modport detect (output set, output sbyte_live);
  modport store  (input set, input sbyte_live, input clear);
endinterface

// *** rtl/i2cab_cause_detect.sv ***
// Turns configuration and bus engine events into one-cycle cause set pulses
`include "i2cab_defines.svh"
module i2cab_cause_detect (
  input  wire i2cab_pkg::i2cab_cfg_t cfg,
  input  wire logic                  xfer_req,
  input  wire logic                  xfer_read,
  input  wire logic                  addr1_nack,
  input  wire logic                  addr2_nack,
  input  wire logic                  data_nack,
  input  wire logic                  start_byte_acked,
  input  wire logic                  hs_code_acked,
  input  wire logic                  read_cmd_popped,
  input  wire logic                  gcall_active,
  i2cab_cause_if.detect              cif
);
  // Start byte request stays illegal while this level holds
  assign cif.sbyte_live = !cfg.restart_en && cfg.cmd_sel_a && cfg.gc_start_sel;

  // One set term per cause
  always_comb begin
    cif.set = '0;
    cif.set[`I2CAB_F_MASTER_DIS] = xfer_req && !cfg.master_en; // R1
    cif.set[`I2CAB_F_10B_RD]     = xfer_req && xfer_read && cfg.ten_bit && !cfg.restart_en; // R2
    cif.set[`I2CAB_F_SB_NORST]   = xfer_req && cif.sbyte_live; // R3
    cif.set[`I2CAB_F_HS_NORST]   = xfer_req && cfg.hs_mode && !cfg.restart_en; // R5
    cif.set[`I2CAB_F_SB_ACKED]   = start_byte_acked; // R6
    cif.set[`I2CAB_F_HS_ACKED]   = hs_code_acked && cfg.hs_mode; // R7
    cif.set[`I2CAB_F_GC_READ]    = read_cmd_popped && gcall_active; // R8
    cif.set[`I2CAB_F_GC_NACK]    = addr1_nack && gcall_active; // R9
    cif.set[`I2CAB_F_DATA_NACK]  = data_nack; // R10
    cif.set[`I2CAB_F_10B2_NACK]  = addr2_nack && cfg.ten_bit; // R11
    cif.set[`I2CAB_F_10B1_NACK]  = addr1_nack && cfg.ten_bit && !gcall_active; // R12
    cif.set[`I2CAB_F_7B_NACK]    = addr1_nack && !cfg.ten_bit && !gcall_active; // R13
  end
endmodule

// *** rtl/i2cab_flags.sv ***
// Sticky cause flags with read clear and start byte re-assertion
`include "i2cab_defines.svh"
module i2cab_flags (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  i2cab_cause_if.store                 cif,
  output      i2cab_pkg::i2cab_cause_t flags_q,
  output      logic                    abort_event_q
);
  logic reassert_q;

  // Sticky storage, a set in the clear cycle survives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= '0; // R16
    end else begin
      flags_q <= (cif.clear ? '0 : flags_q) | cif.set |
                 ({{2{1'b0}}, reassert_q, {9{1'b0}}}); // R14 R17 R4
    end
  end

  // Start byte flag comes back one cycle after a clear if still illegal
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reassert_q <= 1'b0;
    end else begin
      reassert_q <= cif.clear && flags_q[`I2CAB_F_SB_NORST] && cif.sbyte_live; // R4
    end
  end

  // Abort event pulse follows any newly detected cause
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      abort_event_q <= 1'b0;
    end else begin
      abort_event_q <= |cif.set; // R15
    end
  end
endmodule

// *** bench/i2cab_chk.sv ***
// Port assertions for the abort cause block
module i2cab_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        xfer_req,
  input wire logic        addr1_nack,
  input wire logic        addr2_nack,
  input wire logic        data_nack,
  input wire logic        start_byte_acked,
  input wire logic        hs_code_acked,
  input wire logic        read_cmd_popped,
  input wire logic        gcall_active,
  input wire logic        master_enable,
  input wire logic        tx_abort_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic any_cause;
  // Any engine event that may raise a flag
  assign any_cause = xfer_req | addr1_nack | addr2_nack | data_nack | start_byte_acked | hs_code_acked | read_cmd_popped;
  mdis_event_a: assert property (xfer_req && !master_enable |=> tx_abort_event)
    else $error("no event for request with master off");
  sbyte_event_a: assert property (start_byte_acked |=> tx_abort_event)
    else $error("no event for acked start byte");
  dnack_event_a: assert property (data_nack |=> tx_abort_event)
    else $error("no event for data nack");
  addr_event_a: assert property (addr1_nack |=> tx_abort_event)
    else $error("no event for address nack");
  gread_event_a: assert property (read_cmd_popped && gcall_active |=> tx_abort_event)
    else $error("no event for read after general call");
  event_pulse_a: assert property (tx_abort_event && !any_cause |=> !tx_abort_event)
    else $error("abort event longer than one cycle");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule

// *** bench/i2cab_eng_model.sv ***
// Behavioural bus engine standing in for the remote I2C devices
module i2cab_eng_model (
  input  wire logic clk,
  output      logic xfer_req,
  output      logic xfer_read,
  output      logic addr1_nack,
  output      logic addr2_nack,
  output      logic data_nack,
  output      logic start_byte_acked,
  output      logic hs_code_acked,
  output      logic read_cmd_popped,
  output      logic gcall_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet bus at time zero
  initial begin
    {xfer_req, xfer_read, addr1_nack, addr2_nack, data_nack} = '0;
    {start_byte_acked, hs_code_acked, read_cmd_popped, gcall_active} = '0;
  end
  // Set the levels, stall a while, then give one event pulse
  task automatic fire(input logic [2:0] c, input logic rd, input logic gc, input int slow);
    @(posedge clk);
    xfer_read    <= rd;
    gcall_active <= gc;
    repeat (slow + 1) @(posedge clk);
    {read_cmd_popped, hs_code_acked, start_byte_acked, data_nack, addr2_nack, addr1_nack, xfer_req} <= 7'h1 << c;
    @(posedge clk);
    {read_cmd_popped, hs_code_acked, start_byte_acked, data_nack, addr2_nack, addr1_nack, xfer_req} <= 7'h0;
  endtask
endmodule

// *** bench/i2cab_tb_top.sv ***
// Self-checking bench for the abort cause block
`include "i2cab_defines.svh"
module i2cab_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, master_enable, repeated_start_enable;
  logic        xfer_req, xfer_read, addr1_nack, addr2_nack, data_nack, start_byte_acked, hs_code_acked;
  logic        read_cmd_popped, gcall_active, tx_abort_event;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  s_axi_awprot, s_axi_arprot, ev_t[12];
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  ctl_t[12];
  logic [11:0] rd_m, gc_m;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          failures, num_checks, seed;

  i2cab_top i_dut (.*);
  i2cab_eng_model i_eng (.*);

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compare a read answer with the oldest note
  task automatic cmp_r(input logic [33:0] e);
    num_checks++;
    if ({s_axi_rresp, s_axi_rdata} !== e) begin
      failures++;
      $display("MISMATCH t=%0t read got %h exp %h", $time, {s_axi_rresp, s_axi_rdata}, e);
    end
  endtask

  // Compare a write response with the oldest note
  task automatic cmp_b(input logic [1:0] e);
    num_checks++;
    if (s_axi_bresp !== e) begin
      failures++;
      $display("MISMATCH t=%0t bresp got %h exp %h", $time, s_axi_bresp, e);
    end
  endtask

  // Compare the configuration outputs with the value just written
  task automatic cmp_o(input logic [1:0] e);
    num_checks++;
    if ({master_enable, repeated_start_enable} !== e) begin
      failures++;
      $display("MISMATCH t=%0t config outputs got %b exp %b", $time, {master_enable, repeated_start_enable}, e);
    end
  endtask

  // Watch both answer channels
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) cmp_r(rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp_b(bq.pop_front());
  end

  // Write one word, releasing each channel once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = `I2CAB_RESP_OKAY);
    bq.push_back(r);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // Read one word and note what it should return
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = `I2CAB_RESP_OKAY);
    rq.push_back({r, v});
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Print counts and verdict, then stop
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end

  // Main sequence
  initial begin
    seed = 32'h3e6aa8a9;
    ctl_t = '{8'h21, 8'h25, 8'h25, 8'h21, 8'h21, 8'h21, 8'h23, 8'h21, 8'h03, 8'h01, 8'h05, 8'h20};
    ev_t = '{3'd1, 3'd1, 3'd2, 3'd3, 3'd1, 3'd6, 3'd5, 3'd4, 3'd0, 3'd0, 3'd0, 3'd0};
    rd_m = 12'h400;
    gc_m = 12'h030;
    {nrst, s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(`I2CAB_ADDR_CONTROL, `I2CAB_CONTROL_RST);
    rd(`I2CAB_ADDR_SOURCE, 32'h0);
    wr(`I2CAB_ADDR_SOURCE, 32'hffff_ffff);
    rd(`I2CAB_ADDR_SOURCE, 32'h0);
    wr(8'h0c, 32'h1, `I2CAB_RESP_SLVERR);
    rd(8'h0c, 32'h0, `I2CAB_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(`I2CAB_ADDR_TARGET, d);
      rd(`I2CAB_ADDR_TARGET, d & `I2CAB_TARGET_MASK);
    end
    wr(`I2CAB_ADDR_TARGET, 32'h0);
    // One cause at a time, then both clear paths
    for (int b = 0; b < 12; b++) begin
      wr(`I2CAB_ADDR_CONTROL, {24'h0, ctl_t[b]});
      cmp_o({ctl_t[b][0], ctl_t[b][5]});
      wr(`I2CAB_ADDR_TARGET, (b == 9) ? 32'hc00 : 32'h0);
      i_eng.fire(ev_t[b], rd_m[b], gc_m[b], $random(seed) & 3);
      rd(`I2CAB_ADDR_SOURCE, 32'h1 << b);
      rd((b % 2) ? `I2CAB_ADDR_INTR_CLR : `I2CAB_ADDR_ABRT_CLR, 32'h1);
      rd(`I2CAB_ADDR_SOURCE, (b == 9) ? 32'h200 : 32'h0);
      wr(`I2CAB_ADDR_TARGET, 32'h0);
      rd(`I2CAB_ADDR_ABRT_CLR, (b == 9) ? 32'h1 : 32'h0);
      rd(`I2CAB_ADDR_SOURCE, 32'h0);
    end
    complete_run();
  end
endmodule

bind i2cab_top i2cab_chk u_chk (.*);
